// file: hw/sleep_wake_pkg.sv
// constants for the sleep / wake-up controller
// assumes a single 100 MHz clock and a classic wishbone register port
package sleep_wake_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned OST_TOSC_PERIODS = 1024;
  // oscillator start-up wait counted in core clocks (one tosc per clock)
  localparam int unsigned OST_CYCLES       = OST_TOSC_PERIODS * CLK_MHZ / CLK_MHZ;
  localparam logic [7:0]  WDT_BASE_RESET   = 8'h00ff;
  localparam int unsigned WDT_BASE_DEFAULT = 255;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_OPTION  = 8'h0081;
  localparam logic [7:0] ADDR_CONTROL = 8'h0090;
  localparam logic [7:0] ADDR_STATUS  = 8'h0094;
  localparam logic [7:0] ADDR_IRQ     = 8'h0098;

  localparam logic [7:0] OPTION_RESET  = 8'h00ff;
  localparam int unsigned PSA_BIT      = 3;
  // control fields
  localparam int unsigned CTL_WDT_EN   = 0;
  localparam int unsigned CTL_OSC_RC   = 1;
  localparam int unsigned CTL_GIE      = 2;
  // irq register fields: enables in [2:0], flags in [6:4]
  localparam int unsigned IRQ_T0       = 0;
  localparam int unsigned IRQ_INT      = 1;
  localparam int unsigned IRQ_RB       = 2;
  localparam logic [6:0]  IRQ_RESET    = 7'h0000;
  localparam logic [2:0]  CTL_RESET    = 3'h0;
  localparam logic [12:0] VECTOR_ADDR  = 13'h0004;
  localparam logic [12:0] PC_RESET     = 13'h0000;
endpackage

// file: hw/sleep_wakeup_control.sv
// sleep / wake-up controller with watchdog, reset cause flags and prescaler routing
// assumes core strobes are one-cycle pulses synchronous to CLK; watchdog tick arrives
// as a one-cycle enable from the slow rc divider in the same clock domain
`timescale 1ns/1ps
module sleep_wakeup_control
  import sleep_wake_pkg::*;
#(
  parameter int unsigned OST_COUNT = OST_CYCLES,
  parameter int unsigned WDT_BASE  = WDT_BASE_DEFAULT
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // core interface
  input  wire logic        SLEEP_EXEC,
  input  wire logic        CLRWDT_EXEC,
  input  wire logic [12:0] CORE_PC,
  input  wire logic        MASTER_CLEAR_PIN_N,
  input  wire logic        WDT_TICK,
  input  wire logic        TIMER_OVF,
  input  wire logic        EXT_IRQ_EVT,
  input  wire logic        PORT_CHG_EVT,
  input  wire logic [7:0]  PIN_OUT_IN,
  input  wire logic [7:0]  PIN_OE_N_IN,
  // outputs
  output logic             CORE_CLK_EN,
  output logic             OSC_DRIVER_EN,
  output logic             CORE_RESET,
  output logic             FETCH_REQ,
  output logic [12:0]      FETCH_ADDR,
  output logic             VECTOR_TAKE,
  output logic             TIMER_TICK,
  output logic             WDT_TIMEOUT,
  output logic [7:0]       PIN_OUT,
  output logic [7:0]       PIN_OE_N,
  output logic             MASTER_CLEAR_OUT,
  output logic             MASTER_CLEAR_OE_N
);
  typedef enum logic [3:0] {
    RUN   = 4'b0001,
    SLEEP = 4'b0010,
    OST   = 4'b0100,
    RESUME = 4'b1000
  } pstate_e;

  typedef struct packed {
    pstate_e     st;
    logic [7:0]  option;
    logic [2:0]  ctl;
    logic [6:0]  irq;
    logic        pd;
    logic        to;
    logic [7:0]  wdt;
    logic [7:0]  psc;
    logic [15:0] ost;
    logic        vec_pend;
    logic        rst_pend;
    logic [31:0] dat;
    logic        ack;
    logic        clk_en;
    logic        osc_en;
    logic        core_rst;
    logic        fetch;
    logic [12:0] faddr;
    logic        vec;
    logic        tmr_tick;
    logic        wdt_to;
    logic [7:0]  pout;
    logic [7:0]  poe_n;
  } state_s;

  state_s s_reg;
  state_s s_next;

  localparam logic [15:0] OST_LAST = 16'(OST_COUNT - 1);
  localparam logic [7:0]  WDT_LAST = 8'(WDT_BASE);

  // prescaler rate decode used both for timer and watchdog
  function automatic logic psc_hit(input logic [7:0] cnt, input logic [2:0] ps,
                                   input logic as_post);
    logic [7:0] mask;
    mask = as_post ? ((8'h0001 << ps) - 8'h0001) : ((8'h0002 << ps) - 8'h0001);
    psc_hit = (cnt & mask) == mask;
  endfunction

  logic [2:0] irq_en;
  logic [2:0] irq_fl;
  logic       wdt_on;
  logic       post;
  logic       wdt_fire;
  logic       pin_wake;
  logic       wb_req;

  always_comb begin
    irq_en   = s_reg.irq[2:0];
    irq_fl   = s_reg.irq[6:4];
    wdt_on   = s_reg.ctl[CTL_WDT_EN];
    post     = s_reg.option[PSA_BIT];
    wdt_fire = wdt_on && WDT_TICK && s_reg.wdt == WDT_LAST &&
               (!post || psc_hit(s_reg.psc, s_reg.option[2:0], 1'b1));
    // of the interrupt flags only pin and port-change can wake; timer flag is excluded
    pin_wake = (irq_en[IRQ_INT] && irq_fl[IRQ_INT]) ||
               (irq_en[IRQ_RB] && irq_fl[IRQ_RB]);
    wb_req   = CYC_I && STB_I && !s_reg.ack;
  end

  always_comb begin
    s_next          = s_reg;
    s_next.ack      = wb_req;
    s_next.fetch    = 1'b0;
    s_next.vec      = 1'b0;
    s_next.tmr_tick = 1'b0;
    s_next.wdt_to   = 1'b0;
    s_next.core_rst = 1'b0;
    s_next.rst_pend = 1'b0;

    // interrupt flags: hardware set wins over software clear below
    if (wb_req && WE_I && ADR_I == ADDR_IRQ && SEL_I[0]) begin
      s_next.irq = DAT_I[6:0];
    end
    if (wb_req && WE_I && ADR_I == ADDR_OPTION && SEL_I[0]) begin
      s_next.option = DAT_I[7:0];
    end
    if (wb_req && WE_I && ADR_I == ADDR_CONTROL && SEL_I[0]) begin
      s_next.ctl = DAT_I[2:0];
    end
    if (EXT_IRQ_EVT) begin
      s_next.irq[4 + IRQ_INT] = 1'b1;
    end
    if (PORT_CHG_EVT) begin
      s_next.irq[4 + IRQ_RB] = 1'b1;
    end

    unique case (ADR_I)
      ADDR_OPTION:  s_next.dat = {24'h0000_00, s_reg.option};
      ADDR_CONTROL: s_next.dat = {29'h0000_0000, s_reg.ctl};
      ADDR_STATUS:  s_next.dat = {24'h0000_00, 2'b00, s_reg.st == SLEEP, s_reg.osc_en,
                                  2'b00, s_reg.to, s_reg.pd};
      ADDR_IRQ:     s_next.dat = {25'h0000_000, s_reg.irq};
      default:      s_next.dat = 32'h0000_0000;
    endcase

    // watchdog counter on the slow tick
    if (wdt_on && WDT_TICK) begin
      if (post) begin
        s_next.psc = s_reg.psc + 8'h01;
      end
      if (!post || psc_hit(s_reg.psc, s_reg.option[2:0], 1'b1)) begin
        s_next.wdt = s_reg.wdt + 8'h01;
      end
    end
    if (CLRWDT_EXEC && s_reg.st == RUN) begin
      s_next.wdt = 8'h00;
      s_next.psc = post ? 8'h00 : s_reg.psc;
    end

    unique case (s_reg.st)
      RUN: begin
        s_next.pout  = PIN_OUT_IN;
        s_next.poe_n = PIN_OE_N_IN;
        if (!post && s_reg.osc_en) begin
          s_next.psc = s_reg.psc + 8'h01;
          s_next.tmr_tick = psc_hit(s_reg.psc, s_reg.option[2:0], 1'b0);
        end
        if (wdt_fire) begin
          // internal reset only; master clear pad is never driven
          s_next.wdt_to   = 1'b1;
          s_next.core_rst = 1'b1;
          s_next.to       = 1'b0;
          s_next.wdt      = 8'h00;
        end else if (SLEEP_EXEC) begin
          s_next.st     = SLEEP;
          s_next.wdt    = 8'h00;
          s_next.psc    = post ? 8'h00 : s_reg.psc;
          s_next.pd     = 1'b0;
          s_next.to     = 1'b1;
          s_next.osc_en = 1'b0;
          s_next.clk_en = 1'b0;
          s_next.fetch  = 1'b1;
          s_next.faddr  = CORE_PC + 13'h0001;
        end
      end
      SLEEP: begin
        // pins frozen at the pre-sleep drive, no core clock
        if (wdt_fire || pin_wake) begin
          s_next.wdt_to = wdt_fire;
          if (wdt_fire) begin
            s_next.to = 1'b0;
          end
          s_next.vec_pend = pin_wake && s_reg.ctl[CTL_GIE];
          s_next.wdt      = 8'h00;
          s_next.psc      = post ? 8'h00 : s_reg.psc;
          s_next.osc_en   = 1'b1;
          s_next.ost      = 16'h0000;
          s_next.st       = s_reg.ctl[CTL_OSC_RC] ? RESUME : OST;
        end
      end
      OST: begin
        s_next.ost = s_reg.ost + 16'h0001;
        if (s_reg.ost == OST_LAST) begin
          s_next.st = RESUME;
        end
      end
      RESUME: begin
        // prefetched instruction runs first, then the vector
        s_next.clk_en   = 1'b1;
        s_next.vec      = s_reg.vec_pend;
        s_next.faddr    = s_reg.vec_pend ? VECTOR_ADDR : s_reg.faddr;
        s_next.vec_pend = 1'b0;
        s_next.st       = RUN;
      end
      default: s_next.st = RUN;
    endcase
  end

  // reset from the master clear pin in any state, asleep or not; to keeps its value and pd clears only when asleep
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg          <= '0;
      s_reg.st       <= RUN;
      s_reg.option   <= OPTION_RESET;
      s_reg.ctl      <= CTL_RESET;
      s_reg.irq      <= IRQ_RESET;
      s_reg.pd       <= 1'b1;
      s_reg.to       <= 1'b1;
      s_reg.clk_en   <= 1'b1;
      s_reg.osc_en   <= 1'b1;
      s_reg.faddr    <= PC_RESET;
      s_reg.poe_n    <= 8'hff;
    end else if (!MASTER_CLEAR_PIN_N) begin
      s_reg          <= '0;
      s_reg.st       <= RUN;
      s_reg.option   <= OPTION_RESET;
      s_reg.pd       <= s_reg.st == SLEEP ? 1'b0 : s_reg.pd;
      s_reg.to       <= s_reg.to;
      s_reg.core_rst <= 1'b1;
      s_reg.clk_en   <= 1'b1;
      s_reg.osc_en   <= 1'b1;
      s_reg.faddr    <= PC_RESET;
      s_reg.poe_n    <= 8'hff;
    end else begin
      s_reg          <= s_next;
    end
  end

  always_comb begin
    DAT_O             = s_reg.dat;
    ACK_O             = s_reg.ack;
    CORE_CLK_EN       = s_reg.clk_en;
    OSC_DRIVER_EN     = s_reg.osc_en;
    CORE_RESET        = s_reg.core_rst;
    FETCH_REQ         = s_reg.fetch;
    FETCH_ADDR        = s_reg.faddr;
    VECTOR_TAKE       = s_reg.vec;
    TIMER_TICK        = s_reg.tmr_tick;
    WDT_TIMEOUT       = s_reg.wdt_to;
    PIN_OUT           = s_reg.pout;
    PIN_OE_N          = s_reg.poe_n;
    MASTER_CLEAR_OUT  = 1'b0;
    MASTER_CLEAR_OE_N = 1'b1;
  end

  sleep_entry_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == RUN && SLEEP_EXEC && !wdt_fire && MASTER_CLEAR_PIN_N |=>
      s_reg.st == SLEEP && !s_reg.pd && s_reg.to && !s_reg.osc_en)
    else $error("sleep entry flags wrong");
  sleep_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == RUN && !SLEEP_EXEC |=> s_reg.st == RUN)
    else $error("sleep without instruction");
  wdt_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == RUN && SLEEP_EXEC && MASTER_CLEAR_PIN_N |=> s_reg.wdt == 8'h00)
    else $error("watchdog not cleared on sleep");
  pin_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == SLEEP && $past(s_reg.st) == SLEEP |-> $stable(PIN_OUT) && $stable(PIN_OE_N))
    else $error("pins changed in sleep");
  master_clear_pin_pad_a: assert property (@(posedge CLK) disable iff (!RST_N)
    MASTER_CLEAR_OE_N)
    else $error("master clear pad driven");
  wdt_wake_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == SLEEP && wdt_fire && MASTER_CLEAR_PIN_N |=> !s_reg.to && s_reg.wdt == 8'h00)
    else $error("watchdog wake flags wrong");
  no_wdt_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !s_reg.ctl[CTL_WDT_EN] && MASTER_CLEAR_PIN_N |=> !WDT_TIMEOUT && !CORE_RESET)
    else $error("disabled watchdog fired");
  rc_skip_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == SLEEP && pin_wake && !wdt_fire && s_reg.ctl[CTL_OSC_RC] && MASTER_CLEAR_PIN_N
      |=> s_reg.st == RESUME ##1 CORE_CLK_EN)
    else $error("rc wake not immediate");
  clk_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == SLEEP || s_reg.st == OST |-> !CORE_CLK_EN)
    else $error("core clock running while asleep");
  vector_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == RESUME && s_reg.vec_pend && MASTER_CLEAR_PIN_N
      |=> VECTOR_TAKE && FETCH_ADDR == VECTOR_ADDR)
    else $error("vector not taken");

  // timer side: the prescaled tick only runs while the core clock runs
  timer_stop_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st != RUN |=> !TIMER_TICK)
    else $error("timer ticked while stopped");
  timer_wake_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == SLEEP && TIMER_OVF && !pin_wake && !wdt_fire && MASTER_CLEAR_PIN_N
      |=> s_reg.st == SLEEP)
    else $error("timer overflow woke the core");

  // master clear wins over every other event, asleep or running
  master_clear_pin_reset_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !MASTER_CLEAR_PIN_N
      |=> CORE_RESET && CORE_CLK_EN && s_reg.st == RUN && FETCH_ADDR == PC_RESET)
    else $error("master clear did not reset");
  fetch_next_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == RUN && SLEEP_EXEC && !wdt_fire && MASTER_CLEAR_PIN_N
      |=> FETCH_REQ && FETCH_ADDR == $past(CORE_PC) + 13'h0001)
    else $error("next address not prefetched");

  // wake sequence: a pending enabled pin or port-change flag ends sleep on the very next edge
  irq_wake_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == SLEEP && pin_wake && MASTER_CLEAR_PIN_N |=> s_reg.st != SLEEP && s_reg.osc_en)
    else $error("enabled interrupt did not wake");
  wake_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == SLEEP && (wdt_fire || pin_wake) && MASTER_CLEAR_PIN_N |=> s_reg.wdt == 8'h00)
    else $error("watchdog not cleared on wake");
  ost_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == OST && s_reg.ost != OST_LAST && MASTER_CLEAR_PIN_N
      |=> s_reg.st == OST && !CORE_CLK_EN)
    else $error("start-up wait cut short");
  ost_done_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == OST && s_reg.ost == OST_LAST && MASTER_CLEAR_PIN_N |=> s_reg.st == RESUME)
    else $error("start-up wait overran");
  resume_inline_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == RESUME && !s_reg.vec_pend && MASTER_CLEAR_PIN_N
      |=> !VECTOR_TAKE && CORE_CLK_EN && FETCH_ADDR == $past(FETCH_ADDR))
    else $error("in-line resume vectored");
  wdt_reset_a: assert property (@(posedge CLK) disable iff (!RST_N)
    s_reg.st == RUN && wdt_fire && MASTER_CLEAR_PIN_N
      |=> CORE_RESET && WDT_TIMEOUT && !s_reg.to && s_reg.st == RUN)
    else $error("running watchdog timeout did not reset");

  // flag set and software clear in one cycle: the set must survive
  pin_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
    EXT_IRQ_EVT && MASTER_CLEAR_PIN_N |=> s_reg.irq[4 + IRQ_INT])
    else $error("pin flag lost");
  port_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
    PORT_CHG_EVT && MASTER_CLEAR_PIN_N |=> s_reg.irq[4 + IRQ_RB])
    else $error("port flag lost");
endmodule

// file: verif/pin_side_model.sv
// pin side of the block: reset pin, interrupt pins and the watchdog rc tick
// assumes bench requests change just after a rising clk edge
`timescale 1ns/1ps
module pin_side_model #(
  parameter int unsigned TICK_DIV = 4
) (
  // clock
  input  wire logic clk,
  // requests from the bench
  input  wire logic pin_req,
  input  wire logic port_req,
  input  wire logic clear_req,
  input  wire logic tick_run,
  // lines seen by the block
  output logic      master_clear_n,
  output logic      ext_evt  = 1'b0,
  output logic      port_evt = 1'b0,
  output logic      wdt_tick = 1'b0
);
  logic       pin_q   = 1'b0;
  logic       port_q  = 1'b0;
  logic [7:0] div_cnt = 8'h00;

  // pulled up: high whenever nobody holds the pin down
  assign master_clear_n = !clear_req;
  always_ff @(posedge clk) begin
    pin_q    <= pin_req;
    port_q   <= port_req;
    ext_evt  <= pin_req & !pin_q;
    port_evt <= port_req & !port_q;
    div_cnt  <= (div_cnt == 8'(TICK_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
    // the rc source keeps ticking while the main clock of the core is stopped
    wdt_tick <= tick_run && (div_cnt == 8'h00);
  end
endmodule

// file: verif/sleep_wakeup_control_tb.sv
// bench for the sleep / wake-up controller: register tasks and sleep scenarios
// assumes the design package and the pin side model are compiled first
`timescale 1ns/1ps
module sleep_wakeup_control_tb
  import sleep_wake_pkg::*;
();
  localparam int unsigned OST = 8;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00, pout = 8'h00, poe_n = 8'hff;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic [12:0] pc = 13'h0000, fetch_adr;
  logic sleep_x = 1'b0, ovf = 1'b0, pin_req = 1'b0, port_req = 1'b0;
  logic clear_req = 1'b0, tick_run = 1'b0, ack, clk_en, osc_en, core_rst, fetch, vec;
  logic t_tick, wdt_to, mc_out, mc_oe_n, mc_src, ext_evt, port_evt, wdt_tick, seen;
  logic [7:0]  pin_o, oe_o;
  wire         mc_pin = mc_oe_n ? mc_src : mc_out;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          n;

  always #5 clk = ~clk;

  sleep_wakeup_control #(.OST_COUNT(OST), .WDT_BASE(3)) u_dut (
    .CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(4'h1), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .SLEEP_EXEC(sleep_x),
    .CLRWDT_EXEC(1'b0), .CORE_PC(pc), .MASTER_CLEAR_PIN_N(mc_pin), .WDT_TICK(wdt_tick),
    .TIMER_OVF(ovf), .EXT_IRQ_EVT(ext_evt), .PORT_CHG_EVT(port_evt), .PIN_OUT_IN(pout),
    .PIN_OE_N_IN(poe_n), .CORE_CLK_EN(clk_en), .OSC_DRIVER_EN(osc_en),
    .CORE_RESET(core_rst), .FETCH_REQ(fetch), .FETCH_ADDR(fetch_adr), .VECTOR_TAKE(vec),
    .TIMER_TICK(t_tick), .WDT_TIMEOUT(wdt_to), .PIN_OUT(pin_o), .PIN_OE_N(oe_o),
    .MASTER_CLEAR_OUT(mc_out), .MASTER_CLEAR_OE_N(mc_oe_n));

  pin_side_model #(.TICK_DIV(4)) u_pins (
    .clk(clk), .pin_req(pin_req), .port_req(port_req), .clear_req(clear_req),
    .tick_run(tick_run), .master_clear_n(mc_src), .ext_evt(ext_evt),
    .port_evt(port_evt), .wdt_tick(wdt_tick));

  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; entered just after a rising edge
  // only the bench watchdog ends a wait that never sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic do_sleep();
    pout <= 8'ha5;
    poe_n <= 8'h0f;
    // firmware keeps a no-op at pc + 1, so the prefetched word is harmless
    pc <= 13'h0100;
    @(posedge clk);
    sleep_x <= 1'b1;
    @(posedge clk);
    sleep_x <= 1'b0;
    @(posedge clk);
    pout <= 8'h5a;
    poe_n <= 8'hf0;
    chk(32'(fetch), 32'h1);
    chk(32'(fetch_adr), 32'h0101);
    chk(32'(osc_en), 32'h0);
    // the tick registered on the sleep edge still belongs to the sleep instruction
    @(posedge clk);
  endtask

  // a no-wake case passes lo == hi and must reach hi with the core still stopped
  task automatic wait_wake(input int lo, input int hi);
    n = 0;
    while (clk_en !== 1'b1 && n < hi) begin
      chk(32'(t_tick), 32'h0);
      chk({16'h0, pin_o, oe_o}, 32'ha50f);
      chk(32'(core_rst), 32'h0);
      @(posedge clk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask

  task automatic watch_vec(input logic exp);
    seen = 1'b0;
    repeat (4) begin
      if (vec === 1'b1) begin
        seen = 1'b1;
        chk(32'(fetch_adr), 32'(VECTOR_ADDR));
      end
      @(posedge clk);
    end
    chk(32'(seen), 32'(exp));
  endtask

  // eight running cycles: the tick alternates when the prescaler serves the timer
  task automatic tick_count(input int exp);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n = n + int'(t_tick);
    end
    chk(32'(n), 32'(exp));
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, ADDR_OPTION, 32'h0000_0000);
    chk(rdat, 32'h0000_00ff);
    tick_count(0);
    wb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0013);
    wb(1'b0, 8'ha0, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    // prescaler to the timer, so the watchdog has no postscaler
    wb(1'b1, ADDR_OPTION, 32'h0000_0000);
    wb(1'b0, ADDR_OPTION, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    tick_count(4);
    wb(1'b1, ADDR_CONTROL, 32'h0000_0002);
    wb(1'b1, ADDR_IRQ, 32'h0000_0002);
    do_sleep();
    wb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0022);
    tick_run <= 1'b1;
    ovf <= 1'b1;
    port_req <= 1'b1;
    wait_wake(20, 20);
    pin_req <= 1'b1;
    wait_wake(1, 6);
    watch_vec(1'b0);
    // port flag left pending and enabled: sleep ends at once
    pin_req <= 1'b0;
    port_req <= 1'b0;
    wb(1'b1, ADDR_IRQ, 32'h0000_0044);
    do_sleep();
    wait_wake(0, 6);
    wb(1'b1, ADDR_CONTROL, 32'h0000_0004);
    wb(1'b1, ADDR_IRQ, 32'h0000_0004);
    do_sleep();
    port_req <= 1'b1;
    wait_wake(OST, OST + 8);
    watch_vec(1'b1);
    wb(1'b1, ADDR_CONTROL, 32'h0000_0003);
    wb(1'b1, ADDR_IRQ, 32'h0000_0000);
    do_sleep();
    wait_wake(1, 60);
    wb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0010);
    n = 0;
    while (wdt_to !== 1'b1 && n < 80) begin
      chk(32'(mc_oe_n), 32'h1);
      @(posedge clk);
      n++;
    end
    chk(32'(wdt_to), 32'h1);
    seen = core_rst;
    @(posedge clk);
    seen = seen | core_rst;
    chk(32'(seen), 32'h1);
    chk(32'({mc_out, mc_oe_n}), 32'h1);
    wb(1'b1, ADDR_CONTROL, 32'h0000_0002);
    do_sleep();
    clear_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(core_rst), 32'h1);
    clear_req <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(clk_en), 32'h1);
    wb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0012);
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge clk);
    chk(32'h0, 32'h1);
    report_and_stop();
  end
endmodule
